// file: hdl/nvc_pkg.sv
package nvc_pkg;
   // pin-level timing, in the units the device specifies
   localparam int unsigned CLOCK_MHZ = 125;
   localparam int unsigned CLOCK_PERIOD_PS = 8000;
   localparam int unsigned STORE_INIT_NS = 45;
   localparam int unsigned RECALL_INIT_NS = 25;
   localparam int unsigned STORE_DURATION_MS = 10;
   localparam int unsigned RECALL_DURATION_US = 20;
   localparam int unsigned WRITE_PULSE_NS = 35;
   localparam int unsigned READ_ACCESS_NS = 45;
   // least times round up, longest waits are what the host must allow, exact products of duration and clock rate
   localparam int unsigned STORE_INIT_CYC = (STORE_INIT_NS * 1000 + CLOCK_PERIOD_PS - 1)
      / CLOCK_PERIOD_PS;
   localparam int unsigned RECALL_INIT_CYC = (RECALL_INIT_NS * 1000 + CLOCK_PERIOD_PS - 1)
      / CLOCK_PERIOD_PS;
   localparam int unsigned WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLOCK_PERIOD_PS - 1)
      / CLOCK_PERIOD_PS;
   localparam int unsigned READ_ACCESS_CYC = (READ_ACCESS_NS * 1000 + CLOCK_PERIOD_PS - 1)
      / CLOCK_PERIOD_PS;
   localparam int unsigned STORE_DURATION_CYC = STORE_DURATION_MS * 1000 * CLOCK_MHZ;
   localparam int unsigned RECALL_DURATION_CYC = RECALL_DURATION_US * CLOCK_MHZ;
   // geometry
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned DEPTH = 512;
   // host commands
   typedef enum logic [2:0]
   {
      NVC_CMD_READ = 3'h0,
      NVC_CMD_WRITE = 3'h1,
      NVC_CMD_STORE = 3'h2,
      NVC_CMD_RECALL = 3'h3,
      NVC_CMD_NOP = 3'h4
   } nvc_cmd_e;
endpackage : nvc_pkg

// file: hdl/nvc_wait.sv
`timescale 1ns/100ps
// loadable down-counter; done is high while the count is zero
module nvc_wait #(
   parameter int unsigned WIDTH = 32
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // control
   input wire logic load,
   input wire logic [WIDTH-1:0] count,
   // status
   output logic done
);
   logic [WIDTH-1:0] remain;
   logic [WIDTH-1:0] next_remain;

   initial
   begin
      if (WIDTH < 2)
         $error("nvc_wait: WIDTH too small");
   end

   assign next_remain = load ? count : (remain != '0 ? remain - WIDTH'(1) : remain);
   assign done = (remain == '0);

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         remain <= '0;
      else
         remain <= next_remain;
   end
endmodule : nvc_wait

// file: hdl/nvc_host.sv
`timescale 1ns/100ps
// Contract
// R1: host selects plain RAM access or nonvolatile transfer via nv_mode_n.
// R2: read drives chip and output enable low, write and nv_mode_n high.
// R3: read data captured after access time while controls hold read state.
// R4: write drives chip and write enable low, nv_mode_n high, data before end.
// R5: address stays stable from before write start until write enable rises.
// R6: device turns off its drivers if output enable stays low in a write.
// R7: host keeps output enable high through every write cycle.
// R8: store drives nv_mode_n, chip and write enable low, output enable high.
// R9: store is entered with write enable as the last falling signal.
// R10: store condition held at least 45 ns, then released.
// R11: host releases store initiation with write enable; device completes alone.
// R12: host waits full store duration with data pins undriven.
// R13: a read condition after store shows completion by active outputs.
// R14: every new store or recall starts from all controls released.
// R15: device refuses store on low supply; host waits out the full duration.
// R16: recall drives chip, output enable, nv_mode_n low, write enable high.
// R17: host waits full recall duration before any further access.
// R18: recall condition held at least 25 ns, then nv_mode_n released.
// R19: recall clears then reloads the array; host may repeat it freely.
// R20: write enable low with store state starts store, not recall.
// R21: host never leaves chip enable low with read-like nonvolatile levels.
// R22: after reset host waits the power-up recall time before any access.
// R23: all four controls low is a no-operation; host never requests it.
module nvc_host #(
   parameter int unsigned STORE_CYC = nvc_pkg::STORE_DURATION_CYC,
   parameter int unsigned RECALL_CYC = nvc_pkg::RECALL_DURATION_CYC,
   parameter int unsigned POWERUP_CYC = nvc_pkg::RECALL_DURATION_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // command port
   input wire logic req_valid,
   input wire nvc_pkg::nvc_cmd_e req_cmd,
   input wire logic [nvc_pkg::ADDR_W-1:0] req_addr,
   input wire logic [nvc_pkg::DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic [nvc_pkg::DATA_W-1:0] rsp_rdata,
   // device pins
   output logic chip_en_n,
   output logic write_en_n,
   output logic out_en_n,
   output logic nv_mode_n,
   output logic [nvc_pkg::ADDR_W-1:0] addr_pins,
   input wire logic [nvc_pkg::DATA_W-1:0] data_pins_in,
   output logic [nvc_pkg::DATA_W-1:0] data_pins_out,
   output logic data_pins_oe_n
);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [6:0]
   {
      ST_POWERUP = 7'h01,
      ST_IDLE = 7'h02,
      ST_SETUP = 7'h04,
      ST_ACTIVE = 7'h08,
      ST_HOLD = 7'h10,
      ST_BUSY = 7'h20,
      ST_RELEASE = 7'h40
   } nvc_state_e;

   localparam int unsigned CNT_W = 32;

   initial
   begin
      if (STORE_CYC < 2 || RECALL_CYC < 2 || POWERUP_CYC < 2)
         $error("nvc_host: durations must be at least two cycles");
   end

   nvc_state_e state;
   nvc_state_e next_state;
   nvc_pkg::nvc_cmd_e cmd;
   logic [nvc_pkg::DATA_W-1:0] wdata;
   logic [nvc_pkg::DATA_W-1:0] sync1;
   logic [nvc_pkg::DATA_W-1:0] sync2;
   logic wait_load;
   logic [CNT_W-1:0] wait_count;
   logic wait_done;
   logic is_nv;
   logic pwr_started;

   ////////////////////////////////////////////////////////////////////////////
   // active cycle length of each command: pulse width, access or initiation hold
   function automatic logic [CNT_W-1:0] active_cycles(input nvc_pkg::nvc_cmd_e c);
      unique case (c)
         nvc_pkg::NVC_CMD_WRITE: active_cycles = CNT_W'(nvc_pkg::WRITE_PULSE_CYC);
         nvc_pkg::NVC_CMD_STORE: active_cycles = CNT_W'(nvc_pkg::STORE_INIT_CYC); // R10
         nvc_pkg::NVC_CMD_RECALL: active_cycles = CNT_W'(nvc_pkg::RECALL_INIT_CYC); // R18
         default: active_cycles = CNT_W'(nvc_pkg::READ_ACCESS_CYC + 2);
      endcase
   endfunction : active_cycles

   assign is_nv = (cmd == nvc_pkg::NVC_CMD_STORE) || (cmd == nvc_pkg::NVC_CMD_RECALL);
   assign req_ready = (state == ST_IDLE);

   // counter loads on each state entry that needs a timed stay
   assign wait_load = (state == ST_POWERUP && !pwr_started)
      || (state == ST_SETUP)
      || (state == ST_HOLD && is_nv)
      || (state == ST_IDLE && req_valid && req_cmd != nvc_pkg::NVC_CMD_NOP);
   assign wait_count = (state == ST_SETUP) ? active_cycles(cmd)
      : (state == ST_HOLD) ? ((cmd == nvc_pkg::NVC_CMD_STORE) ? CNT_W'(STORE_CYC)
      : CNT_W'(RECALL_CYC)) // R12 R15 R17
      : (state == ST_POWERUP) ? CNT_W'(POWERUP_CYC) // R22
      : CNT_W'(1);

   nvc_wait #(
      .WIDTH(CNT_W)
   ) u_wait (
      .clock(clock),
      .nrst(nrst),
      .load(wait_load),
      .count(wait_count),
      .done(wait_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_POWERUP: if (pwr_started && wait_done) next_state = ST_RELEASE; // R22
         // nop requests are dropped: all-low controls do nothing
         ST_IDLE: if (req_valid && req_cmd != nvc_pkg::NVC_CMD_NOP) next_state = ST_SETUP; // R23
         ST_SETUP: next_state = ST_ACTIVE;
         ST_ACTIVE: if (wait_done) next_state = ST_HOLD;
         ST_HOLD: next_state = is_nv ? ST_BUSY : ST_RELEASE;
         ST_BUSY: if (wait_done) next_state = ST_RELEASE;
         ST_RELEASE: next_state = ST_IDLE;
         default: next_state = ST_POWERUP;
      endcase
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         state <= ST_POWERUP;
      else
         state <= next_state;
   end

   // the counter leaves reset at zero, so power-up arms it once before waiting on it
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         pwr_started <= 1'b0;
      else if (state == ST_POWERUP)
         pwr_started <= 1'b1;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         cmd <= nvc_pkg::NVC_CMD_READ;
         addr_pins <= '0;
         wdata <= '0;
      end
      else if (state == ST_IDLE && req_valid)
      begin
         cmd <= req_cmd;
         addr_pins <= req_addr; // R5
         wdata <= req_wdata;
      end
   end

   // read data crosses in from the pins through two flops
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else
      begin
         sync1 <= data_pins_in;
         sync2 <= sync1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin levels: setup puts nv_mode_n, out_en_n and, except for recall, chip_en_n in place first, the
   // active state then drops the trigger pin last so no stray write can occur
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         chip_en_n <= 1'b1;
         write_en_n <= 1'b1;
         out_en_n <= 1'b1;
         nv_mode_n <= 1'b1;
         data_pins_out <= '0;
         data_pins_oe_n <= 1'b1;
      end
      else
      begin
         unique case (next_state)
            ST_SETUP:
            begin
               nv_mode_n <= !is_nv_cmd(req_cmd); // R1
               out_en_n <= (req_cmd != nvc_pkg::NVC_CMD_READ)
                  && (req_cmd != nvc_pkg::NVC_CMD_RECALL); // R7 R8 R21
               chip_en_n <= (req_cmd == nvc_pkg::NVC_CMD_RECALL); // R21
               write_en_n <= 1'b1;
               data_pins_out <= req_wdata;
               data_pins_oe_n <= (req_cmd != nvc_pkg::NVC_CMD_WRITE); // R4 R6
            end
            ST_ACTIVE:
            begin
               chip_en_n <= 1'b0; // R2 R16
               write_en_n <= !((cmd == nvc_pkg::NVC_CMD_WRITE)
                  || (cmd == nvc_pkg::NVC_CMD_STORE)); // R4 R9 R20
            end
            ST_HOLD:
            begin
               write_en_n <= 1'b1; // R11
               nv_mode_n <= 1'b1; // R18
               chip_en_n <= is_nv ? 1'b1 : chip_en_n;
            end
            ST_BUSY, ST_RELEASE, ST_IDLE, ST_POWERUP:
            begin
               chip_en_n <= 1'b1; // R14
               write_en_n <= 1'b1;
               out_en_n <= 1'b1;
               nv_mode_n <= 1'b1;
               data_pins_oe_n <= 1'b1; // R12
            end
            default:
            begin
               chip_en_n <= 1'b1;
            end
         endcase
      end
   end

   function automatic logic is_nv_cmd(input nvc_pkg::nvc_cmd_e c);
      is_nv_cmd = (c == nvc_pkg::NVC_CMD_STORE) || (c == nvc_pkg::NVC_CMD_RECALL);
   endfunction : is_nv_cmd

   // read data sampled at the end of the access window, after the sync delay
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end
      else
      begin
         // nonvolatile commands answer only once the full busy wait has run out
         rsp_valid <= (state == ST_HOLD && !is_nv) || (state == ST_BUSY && wait_done); // R13 R19
         if (state == ST_ACTIVE && wait_done && cmd == nvc_pkg::NVC_CMD_READ)
            rsp_rdata <= sync2; // R3
      end
   end
endmodule : nvc_host

// file: test/nvc_host_chk.sv
`timescale 1ns/100ps
module nvc_host_chk #(
   parameter int unsigned POWERUP_CYC = 2500
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // host side
   input wire logic req_ready,
   input wire logic rsp_valid,
   // pins
   input wire logic chip_en_n,
   input wire logic write_en_n,
   input wire logic out_en_n,
   input wire logic nv_mode_n,
   input wire logic [nvc_pkg::ADDR_W-1:0] addr_pins,
   input wire logic data_pins_oe_n
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   int unsigned cyc;
   wire st_on = !nv_mode_n && !chip_en_n && !write_en_n && out_en_n;
   wire rc_on = !nv_mode_n && !chip_en_n && write_en_n && !out_en_n;
   // saturates so it cannot wrap in a long run
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         cyc <= 0;
      else if (cyc < POWERUP_CYC)
         cyc <= cyc + 1;
   ////////////////////////////////////////////////////////////////////////////
   property p_oe; !data_pins_oe_n |-> out_en_n && nv_mode_n; endproperty
   a_oe: assert property (p_oe) else $error("data driven with oe low");
   property p_nop; chip_en_n || write_en_n || out_en_n || nv_mode_n; endproperty
   a_nop: assert property (p_nop) else $error("all controls low");
   property p_addr; !chip_en_n && !write_en_n |=> $stable(addr_pins); endproperty
   a_addr: assert property (p_addr) else $error("address moved in write");
   property p_sth; $fell(write_en_n) && !nv_mode_n |-> st_on [*6]; endproperty
   a_sth: assert property (p_sth) else $error("store held too short");
   property p_stl; $fell(write_en_n) && st_on |-> $past(!nv_mode_n && out_en_n); endproperty
   a_stl: assert property (p_stl) else $error("store not entered by write");
   property p_rch; $fell(chip_en_n) && rc_on |-> rc_on [*4]; endproperty
   a_rch: assert property (p_rch) else $error("recall held too short");
   property p_rel; rsp_valid |-> chip_en_n && write_en_n && nv_mode_n; endproperty
   a_rel: assert property (p_rel) else $error("controls not released");
   property p_pwr; req_ready |-> cyc >= POWERUP_CYC; endproperty
   a_pwr: assert property (p_pwr) else $error("ready before power-up recall");
endmodule : nvc_host_chk
bind nvc_host nvc_host_chk #(.POWERUP_CYC(POWERUP_CYC)) i_nvc_host_chk (.clock(clock),
   .nrst(nrst), .req_ready(req_ready), .rsp_valid(rsp_valid), .chip_en_n(chip_en_n),
   .write_en_n(write_en_n), .out_en_n(out_en_n), .nv_mode_n(nv_mode_n),
   .addr_pins(addr_pins), .data_pins_oe_n(data_pins_oe_n));

// file: test/nvc_dev_model.sv
`timescale 1ns/100ps
// nonvolatile copy survives reset; sram reloads from it
module nvc_dev_model #(
   parameter int unsigned BUSY = 15,
   // supply sense: a low supply refuses every store start
   parameter bit SUPPLY_OK = 1'b1
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // pins
   input wire logic chip_en_n,
   input wire logic write_en_n,
   input wire logic out_en_n,
   input wire logic nv_mode_n,
   input wire logic [nvc_pkg::ADDR_W-1:0] addr_pins,
   input wire logic [nvc_pkg::DATA_W-1:0] bus,
   output logic [nvc_pkg::DATA_W-1:0] dev_data
);
   logic [7:0] mem [nvc_pkg::DEPTH];
   logic [7:0] nv [nvc_pkg::DEPTH];
   logic [7:0] last;
   logic [3:0] prev;
   int busy;
   wire [3:0] pins = {chip_en_n, write_en_n, out_en_n, nv_mode_n};
   wire st = pins == 4'h2;
   wire rc = pins == 4'h4;
   wire rd = pins == 4'h5 && busy == 0;
   // undriven bus shows the inverse, so a stale value never reads back
   assign dev_data = rd ? mem[addr_pins] : ~last;
   initial
      for (int i = 0; i < nvc_pkg::DEPTH; i++)
         nv[i] = i[7:0] ^ 8'h5A;
   always @(posedge clock)
      last <= dev_data;
   always @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         busy <= BUSY;
         prev <= 4'hF;
         mem <= nv;
      end
      else
      begin
         prev <= pins;
         if (busy != 0)
            busy <= busy - 1;
         else if (st && prev != pins && SUPPLY_OK)
         begin
            nv <= mem;
            busy <= BUSY;
         end
         else if (rc && prev != pins)
         begin
            mem <= nv;
            busy <= BUSY;
         end
         else if (!chip_en_n && !write_en_n && nv_mode_n)
            mem[addr_pins] <= bus;
      end
endmodule : nvc_dev_model

// file: test/tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, (a), (e)); end end
module tb;
   localparam int unsigned CYC = 20;
   localparam nvc_pkg::nvc_cmd_e RD = nvc_pkg::NVC_CMD_READ;
   localparam nvc_pkg::nvc_cmd_e WR = nvc_pkg::NVC_CMD_WRITE;
   localparam nvc_pkg::nvc_cmd_e ST = nvc_pkg::NVC_CMD_STORE;
   localparam nvc_pkg::nvc_cmd_e RC = nvc_pkg::NVC_CMD_RECALL;
   logic clock = 1'h0;
   logic nrst = 1'h0;
   logic req_valid = 1'h0;
   nvc_pkg::nvc_cmd_e req_cmd = nvc_pkg::NVC_CMD_NOP;
   logic [8:0] req_addr = 9'h000, addr_pins, note;
   logic [7:0] req_wdata = 8'h00, rsp_rdata, data_pins_out, dev_data;
   logic req_ready, rsp_valid, chip_en_n, write_en_n, out_en_n, nv_mode_n, data_pins_oe_n;
   logic [7:0] sx [512];
   logic [7:0] nx [512];
   logic [8:0] al [6];
   logic [8:0] notes [$];
   logic [31:0] seed = 32'h9CC3F6B6;
   int mismatches = 0;
   int compares = 0;
   int n;
   wire [7:0] bus = data_pins_oe_n ? dev_data : data_pins_out;
   nvc_host #(.STORE_CYC(CYC), .RECALL_CYC(CYC), .POWERUP_CYC(CYC)) i_nvc_host (.clock(clock),
      .nrst(nrst), .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .chip_en_n(chip_en_n), .write_en_n(write_en_n),
      .out_en_n(out_en_n), .nv_mode_n(nv_mode_n), .addr_pins(addr_pins),
      .data_pins_in(bus), .data_pins_out(data_pins_out), .data_pins_oe_n(data_pins_oe_n));
   nvc_dev_model i_nvc_dev_model (.clock(clock), .nrst(nrst), .chip_en_n(chip_en_n),
      .write_en_n(write_en_n), .out_en_n(out_en_n), .nv_mode_n(nv_mode_n),
      .addr_pins(addr_pins), .bus(bus), .dev_data(dev_data));
   always #4 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic results;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results
   // ready depends on state only, so testing it at the falling edge is race free
   task automatic req(input nvc_pkg::nvc_cmd_e c, input logic [8:0] a, input logic [7:0] d);
      @(negedge clock);
      req_valid <= 1'h1;
      req_cmd <= c;
      req_addr <= a;
      req_wdata <= d;
      while (req_ready !== 1'h1)
         @(negedge clock);
      @(posedge clock);
      if (c != nvc_pkg::NVC_CMD_NOP)
         notes.push_back({c == RD, sx[a]});
      if (c == WR)
         sx[a] = d;
      if (c == ST)
         nx = sx;
      if (c == RC)
         sx = nx;
      @(negedge clock);
      req_valid <= 1'h0;
      n = 0;
      while (c != nvc_pkg::NVC_CMD_NOP && rsp_valid !== 1'h1)
      begin
         @(negedge clock);
         n++;
      end
      if (c == ST || c == RC)
         `CHK(n >= CYC, 1'h1)
   endtask : req
   always @(negedge clock)
      if (rsp_valid === 1'h1)
      begin
         note = notes.pop_front();
         if (note[8])
            `CHK(rsp_rdata, note[7:0])
      end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      for (int i = 0; i < 512; i++)
      begin
         nx[i] = i[7:0] ^ 8'h5A;
         sx[i] = nx[i];
      end
      repeat (16) @(negedge clock);
      nrst <= 1'h1;
      foreach (al[i])
      begin
         seed = xs(seed);
         al[i] = i == 0 ? 9'h000 : i == 1 ? 9'h1FF : seed[8:0];
         req(RD, al[i], 8'h00);
      end
      // second pass overwrites after the store, so recall must undo it
      for (int k = 0; k < 2; k++)
      begin
         foreach (al[i])
         begin
            seed = xs(seed);
            req(WR, al[i], seed[7:0]);
            req(RD, al[i], 8'h00);
         end
         if (k == 0)
            req(ST, 9'h000, 8'h00);
      end
      req(nvc_pkg::NVC_CMD_NOP, 9'h000, 8'h00);
      req(RC, 9'h000, 8'h00);
      req(RC, 9'h000, 8'h00);
      foreach (al[i])
         req(RD, al[i], 8'h00);
      results();
   end
   initial
   begin
      #100000;
      mismatches++;
      results();
   end
endmodule : tb
